// ===== testbench/lpddr2_ca_command_decoder_tb_top.sv
// bench top: controller and decoder joined by the link, driven over avalon-mm
// assumes package, link interface, design ends and checker compiled first
`timescale 1ns/1ps
module lpddr2_ca_command_decoder_tb_top;
    logic i_core_clk, i_resetn, i_read, i_write, o_waitrequest, o_cmd_valid, o_ap;
    logic o_all_bank, o_illegal, o_autopre_valid;
    logic [3:0] i_address, last_cmd;
    logic [31:0] i_writedata, o_readdata, q;
    lpddr2_ca_pkg::cmd_t o_cmd;
    lpddr2_ca_pkg::pwr_t o_pwr;
    logic [14:0] o_row;
    logic [11:0] o_col;
    logic [7:0] o_mr_addr, o_mr_op;
    logic [2:0] o_bank, o_autopre_bank;
    int miscompares, samples_checked, cycles, illegal_seen;
    lpddr2_ca_link_if link();
    lpddr2_ca_ctrl lpddr2_ca_ctrl_inst (.i_core_clk, .i_resetn, .i_address, .i_read, .i_write,
        .i_writedata, .o_readdata, .o_waitrequest, .link(link.ctrl));
    lpddr2_ca_device lpddr2_ca_device_inst (.i_core_clk, .i_resetn, .link(link.dev), .o_cmd_valid,
        .o_cmd, .o_row, .o_bank, .o_col, .o_ap, .o_all_bank, .o_mr_addr, .o_mr_op, .o_illegal,
        .o_pwr, .o_autopre_valid, .o_autopre_bank);
    lpddr2_ca_props props_inst (.i_core_clk, .i_resetn, .cs_n(link.cs_n), .cke(link.cke),
        .ca(link.ca), .o_cmd_valid, .o_cmd, .o_row, .o_bank, .o_col, .o_ap, .o_all_bank,
        .o_mr_addr, .o_mr_op, .o_pwr, .o_autopre_valid, .o_autopre_bank);
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        i_address <= a;
        i_read <= !w;
        i_write <= w;
        i_writedata <= d;
        do @(posedge i_core_clk); while (o_waitrequest !== 1'h0);
        q = o_readdata;
        i_read <= 1'h0;
        i_write <= 1'h0;
        @(posedge i_core_clk);
    endtask
    // issue a command code, then poll status until not busy
    task automatic run(input logic [3:0] c);
        bus(4'h0, 1'h1, {28'h0, c});
        do bus(4'hc, 1'h0, 32'h0); while (q[0] !== 1'h0);
    endtask
    initial begin
        i_core_clk = 1'h0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        if (o_cmd_valid) last_cmd <= o_cmd;
        if (o_illegal) illegal_seen <= illegal_seen + 1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        i_resetn = 1'h0;
        i_read = 1'h0;
        i_write = 1'h0;
        i_address = 4'h0;
        i_writedata = 32'h0;
        repeat (5) @(posedge i_core_clk);
        i_resetn <= 1'h1;
        @(posedge i_core_clk);
        bus(4'h4, 1'h1, 32'h5a3d);
        bus(4'h8, 1'h1, 32'hc31d);
        for (int c = 1; c <= 9; c++) begin
            run(c[3:0]);
            check("command", last_cmd, c);
            if (c == 1) check("mode operand", o_mr_op, 32'hc3);
            if (c == 2) check("mode address", o_mr_addr, 32'h3d);
            if (c == 5) check("row", o_row, 32'h5a3d);
            if (c == 6 || c == 7) check("column", o_col, 32'ha3c);
            if (c == 7) check("auto precharge", o_ap, 32'h1);
            if (c == 8) check("all banks", o_all_bank, 32'h1);
            if (c >= 5) check("bank", o_bank, (c == 9) ? 32'h0 : 32'h5);
        end
        $display("command test done");
        for (int c = 10; c <= 12; c++) begin
            run(c[3:0]);
            check("power level", o_pwr, 32'h1 << (c - 9));
            run(4'hd);
            check("exit level", o_pwr, 32'h1);
            check("exit command", last_cmd, 32'hd);
        end
        $display("power test done");
        run(4'hd);
        check("locked", q[1], 32'h1);
        bus(4'h2, 1'h0, 32'h0);
        check("unmapped read", q, 32'h0);
        $display("lock test done");
        check("illegal pulses", illegal_seen, 32'h0);
        report_and_stop();
    end
endmodule

// ===== testbench/lpddr2_ca_props.sv
// link wire checks tied to the decoder outputs
// assumes instantiation beside the link interface, one core clock
`timescale 1ns/1ps
module lpddr2_ca_props (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic cs_n,
    input wire logic cke,
    input wire logic [9:0] ca,
    input wire logic o_cmd_valid,
    input wire lpddr2_ca_pkg::cmd_t o_cmd,
    input wire logic [14:0] o_row,
    input wire logic [2:0] o_bank,
    input wire logic [11:0] o_col,
    input wire logic o_ap,
    input wire logic o_all_bank,
    input wire logic [7:0] o_mr_addr,
    input wire logic [7:0] o_mr_op,
    input wire lpddr2_ca_pkg::pwr_t o_pwr,
    input wire logic o_autopre_valid,
    input wire logic [2:0] o_autopre_bank
);
    logic [9:0] fall;
    logic cke_d;
    wire live = !cs_n && cke && cke_d;
    always_ff @(negedge i_core_clk) fall <= ca;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) cke_d <= 1'h1;
        else cke_d <= cke;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    nop_quiet_a: assert property (
        (cs_n || ca[2:0] == 3'h7) && cke && cke_d |=> ##1 !o_cmd_valid)
        else $error("nop decoded");
    mrw_fields_a: assert property (
        live && ca[3:0] == 4'h0 |=> ##1 o_cmd_valid && o_cmd == 4'h1
        && o_mr_op == $past(fall[9:2])
        && o_mr_addr == {$past(fall[1:0]), $past(ca[9:4], 2)})
        else $error("mode write fields");
    ref_kind_a: assert property (
        live && ca[2:0] == 3'h4 |=> ##1 o_cmd == ($past(ca[3], 2) ? 4'h4 : 4'h3))
        else $error("refresh");
    act_fields_a: assert property (
        live && ca[1:0] == 2'h2 |=> ##1 o_cmd == 4'h5 && o_bank == $past(ca[9:7], 2)
        && o_row == {$past(fall[9:8]), $past(ca[6:2], 2), $past(fall[7:0])})
        else $error("activate fields");
    rdwr_fields_a: assert property (
        live && ca[1:0] == 2'h1 |=> ##1 o_cmd == ($past(ca[2], 2) ? 4'h7 : 4'h6)
        && o_ap == $past(fall[0])
        && o_col == {$past(fall[9:1]), $past(ca[6:5], 2), 1'h0}) else $error("access fields");
    pre_fields_a: assert property (
        live && ca[3:0] == 4'hb |=> ##1 o_cmd == 4'h8 && o_all_bank == $past(ca[4], 2)
        && o_bank == $past(ca[9:7], 2)) else $error("precharge fields");
    pd_entry_a: assert property (
        cs_n && !cke && cke_d ##1 o_pwr == 4'h1 |=> o_pwr == 4'h2) else $error("pd entry");
    deep_entry_a: assert property (
        !cs_n && !cke && cke_d && (ca[2:0] == 3'h4 || ca[2:0] == 3'h3) ##1 o_pwr == 4'h1
        |=> o_pwr == ($past(ca[0], 2) ? 4'h8 : 4'h4)) else $error("low power entry");
    exit_seen_a: assert property (
        cs_n && cke && !cke_d ##1 o_pwr != 4'h1
        |=> o_cmd_valid && o_cmd == 4'hd && o_pwr == 4'h1) else $error("exit missed");
    exit_quiet_a: assert property (
        cs_n && cke && !cke_d |-> cs_n [*3]) else $error("command inside exit time");
    autopre_due_a: assert property (
        o_cmd_valid && o_ap && (o_cmd == 4'h6 || o_cmd == 4'h7) |-> ##4 o_autopre_valid
        && o_autopre_bank == $past(o_bank, 4)) else $error("auto precharge");
endmodule

// ===== verilog/lpddr2_ca_ctrl.sv
// controller end: takes commands over avalon-mm, drives the link
// assumes the device end samples on the same clock, rise then fall
`timescale 1ns/1ps
module lpddr2_ca_ctrl (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    lpddr2_ca_link_if.ctrl link
);
    localparam logic [lpddr2_ca_pkg::XP_W-1:0] XP_LOAD =
        (lpddr2_ca_pkg::XP_W)'(lpddr2_ca_pkg::PD_EXIT_CYC);
    localparam logic [lpddr2_ca_pkg::XP_W-1:0] XP_ONE = 4'h1;
    localparam logic [lpddr2_ca_pkg::XP_W-1:0] XP_ZERO = 4'h0;

    lpddr2_ca_pkg::cmd_t cmd;
    lpddr2_ca_pkg::pwr_t pwr;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic pend;
    logic locked;
    logic cke_hold;
    logic [lpddr2_ca_pkg::XP_W-1:0] xp_cnt;
    logic [lpddr2_ca_pkg::CA_W-1:0] p_half;
    logic [lpddr2_ca_pkg::CA_W-1:0] n_half;
    logic cs_o;
    logic cke_o;
    logic [lpddr2_ca_pkg::CA_W-1:0] enc_rise;
    logic [lpddr2_ca_pkg::CA_W-1:0] enc_fall;
    logic enc_cs_n;

    wire busy = pend | (xp_cnt != XP_ZERO);
    wire is_ctrl = (i_address == lpddr2_ca_pkg::REG_CTRL);
    wire accept = ~(i_write & is_ctrl & busy);
    wire fire = (i_read | i_write) & ~o_waitrequest;
    wire next_wait = ~((i_read | i_write) & o_waitrequest & accept);
    wire [3:0] wcode = i_writedata[3:0];
    wire is_act = (pwr == lpddr2_ca_pkg::PWR_ACTIVE);
    wire code_exit = (wcode == lpddr2_ca_pkg::CMD_EXIT);
    wire code_ok = (wcode <= lpddr2_ca_pkg::CMD_EXIT) & (is_act ^ code_exit);
    wire issue = fire & i_write & is_ctrl & ~locked;
    wire enter = (cmd == lpddr2_ca_pkg::CMD_PD_ENTER) | (cmd == lpddr2_ca_pkg::CMD_SELF_REFRESH_STATE_ENTER)
                 | (cmd == lpddr2_ca_pkg::CMD_DPD_ENTER);
    wire is_exit = (cmd == lpddr2_ca_pkg::CMD_EXIT);
    wire enc_cke = enter ? 1'b0 : is_exit ? 1'b1 : cke_hold;
    wire [lpddr2_ca_pkg::CA_W-1:0] rise_out = pend ? enc_rise : '0;
    wire [lpddr2_ca_pkg::CA_W-1:0] fall_out = pend ? enc_fall : '0;

    wire [31:0] status = {24'h0, pwr, 2'h0, locked, busy};
    wire [31:0] rmux = is_ctrl ? {28'h0, cmd} :
                       (i_address == lpddr2_ca_pkg::REG_ARG0) ? arg0 :
                       (i_address == lpddr2_ca_pkg::REG_ARG1) ? arg1 :
                       (i_address == lpddr2_ca_pkg::REG_STATUS) ? status : 32'h0;

    // command word build for each half
    always_comb begin
        enc_rise = '0;
        enc_fall = '0;
        enc_cs_n = 1'b0;
        case (cmd)
            lpddr2_ca_pkg::CMD_MRW, lpddr2_ca_pkg::CMD_MRR: begin
                enc_rise[lpddr2_ca_pkg::OP4_HI:0] = (cmd == lpddr2_ca_pkg::CMD_MRW) ?
                    lpddr2_ca_pkg::OPC_MRW : lpddr2_ca_pkg::OPC_MRR;
                enc_rise[lpddr2_ca_pkg::R_MA_HI:lpddr2_ca_pkg::R_MA_LO] =
                    arg0[lpddr2_ca_pkg::MA_RISE_W-1:0];
                enc_fall[lpddr2_ca_pkg::F_MA_HI:0] =
                    arg0[lpddr2_ca_pkg::MR_W-1:lpddr2_ca_pkg::MA_RISE_W];
                if (cmd == lpddr2_ca_pkg::CMD_MRW) begin
                    enc_fall[lpddr2_ca_pkg::F_OP_HI:lpddr2_ca_pkg::F_OP_LO] =
                        arg1[lpddr2_ca_pkg::A1_OP_HI:lpddr2_ca_pkg::A1_OP_LO];
                end
            end
            lpddr2_ca_pkg::CMD_REF_PB, lpddr2_ca_pkg::CMD_REF_AB: begin
                enc_rise[lpddr2_ca_pkg::OP3_HI:0] = lpddr2_ca_pkg::OPC_REF;
                enc_rise[lpddr2_ca_pkg::REF_AB_BIT] = (cmd == lpddr2_ca_pkg::CMD_REF_AB);
            end
            lpddr2_ca_pkg::CMD_ACT: begin
                enc_rise[lpddr2_ca_pkg::OP2_HI:0] = lpddr2_ca_pkg::OPC_ACT;
                enc_rise[lpddr2_ca_pkg::R_ROW_HI:lpddr2_ca_pkg::R_ROW_LO] = arg0[12:8];
                enc_rise[lpddr2_ca_pkg::R_BANK_HI:lpddr2_ca_pkg::R_BANK_LO] = arg1[2:0];
                enc_fall[lpddr2_ca_pkg::F_ROWL_HI:0] = arg0[7:0];
                enc_fall[lpddr2_ca_pkg::F_ROWH_HI:lpddr2_ca_pkg::F_ROWH_LO] = arg0[14:13];
            end
            lpddr2_ca_pkg::CMD_WR, lpddr2_ca_pkg::CMD_RD: begin
                enc_rise[lpddr2_ca_pkg::OP3_HI:0] = (cmd == lpddr2_ca_pkg::CMD_WR) ?
                    lpddr2_ca_pkg::OPC_WR : lpddr2_ca_pkg::OPC_RD;
                enc_rise[lpddr2_ca_pkg::R_COL_HI:lpddr2_ca_pkg::R_COL_LO] = arg0[2:1];
                enc_rise[lpddr2_ca_pkg::R_BANK_HI:lpddr2_ca_pkg::R_BANK_LO] = arg1[2:0];
                enc_fall[lpddr2_ca_pkg::F_AP_BIT] = arg1[lpddr2_ca_pkg::A1_AP_BIT];
                enc_fall[lpddr2_ca_pkg::F_COL_HI:lpddr2_ca_pkg::F_COL_LO] = arg0[11:3];
            end
            lpddr2_ca_pkg::CMD_PRE: begin
                enc_rise[lpddr2_ca_pkg::OP4_HI:0] = lpddr2_ca_pkg::OPC_PRE;
                enc_rise[lpddr2_ca_pkg::R_AB_BIT] = arg1[lpddr2_ca_pkg::A1_AB_BIT];
                enc_rise[lpddr2_ca_pkg::R_BANK_HI:lpddr2_ca_pkg::R_BANK_LO] = arg1[2:0];
            end
            lpddr2_ca_pkg::CMD_BST: enc_rise[lpddr2_ca_pkg::OP4_HI:0] = lpddr2_ca_pkg::OPC_BST;
            lpddr2_ca_pkg::CMD_SELF_REFRESH_STATE_ENTER:
                enc_rise[lpddr2_ca_pkg::OP3_HI:0] = lpddr2_ca_pkg::OPC_SELF_REFRESH_STATE;
            lpddr2_ca_pkg::CMD_DPD_ENTER:
                enc_rise[lpddr2_ca_pkg::OP3_HI:0] = lpddr2_ca_pkg::OPC_DPD;
            default: enc_cs_n = 1'b1;
        endcase
    end

    // avalon slave and command sequencing
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0;
            cmd <= lpddr2_ca_pkg::CMD_NOP;
            arg0 <= 32'h0;
            arg1 <= 32'h0;
            pend <= 1'b0;
            locked <= 1'b0;
            cke_hold <= 1'b1;
            pwr <= lpddr2_ca_pkg::PWR_ACTIVE;
            xp_cnt <= XP_ZERO;
            p_half <= '0;
        end else begin
            o_waitrequest <= next_wait;
            if (o_waitrequest & ~next_wait) begin
                o_readdata <= rmux;
            end
            if (fire & i_write & (i_address == lpddr2_ca_pkg::REG_ARG0)) begin
                arg0 <= i_writedata;
            end
            if (fire & i_write & (i_address == lpddr2_ca_pkg::REG_ARG1)) begin
                arg1 <= i_writedata;
            end
            if (issue & code_ok) begin
                cmd <= lpddr2_ca_pkg::cmd_t'(wcode);
                pend <= 1'b1;
            end else if (pend) begin
                pend <= 1'b0;
                cke_hold <= enc_cke;
            end
            if (issue & ~code_ok) begin
                locked <= 1'b1;
            end
            if (pend & is_exit) begin
                pwr <= lpddr2_ca_pkg::PWR_ACTIVE;
                xp_cnt <= XP_LOAD;
            end else if (xp_cnt != XP_ZERO) begin
                xp_cnt <= xp_cnt - XP_ONE;
            end
            if (pend & (cmd == lpddr2_ca_pkg::CMD_PD_ENTER)) begin
                pwr <= lpddr2_ca_pkg::PWR_PD;
            end
            if (pend & (cmd == lpddr2_ca_pkg::CMD_SELF_REFRESH_STATE_ENTER)) begin
                pwr <= lpddr2_ca_pkg::PWR_SELF_REFRESH_STATE;
            end
            if (pend & (cmd == lpddr2_ca_pkg::CMD_DPD_ENTER)) begin
                pwr <= lpddr2_ca_pkg::PWR_DPD;
            end
            p_half <= fall_out ^ n_half;
        end
    end

    // rising half, cs and cke set up half a cycle early
    always_ff @(negedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            n_half <= '0;
            cs_o <= 1'b1;
            cke_o <= 1'b1;
        end else begin
            n_half <= rise_out ^ p_half;
            cs_o <= pend ? enc_cs_n : 1'b1;
            cke_o <= pend ? enc_cke : cke_hold;
        end
    end

    assign link.ca = p_half ^ n_half;
    assign link.cs_n = cs_o;
    assign link.cke = cke_o;
endmodule

// ===== verilog/lpddr2_ca_device.sv
// memory-side command decoder of the command/address link
// assumes the controller end drives ca, cs_n and cke from the same clock
`timescale 1ns/1ps
module lpddr2_ca_device (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    lpddr2_ca_link_if.dev link,
    output logic o_cmd_valid,
    output lpddr2_ca_pkg::cmd_t o_cmd,
    output logic [lpddr2_ca_pkg::ROW_W-1:0] o_row,
    output logic [lpddr2_ca_pkg::BANK_W-1:0] o_bank,
    output logic [lpddr2_ca_pkg::COL_W-1:0] o_col,
    output logic o_ap,
    output logic o_all_bank,
    output logic [lpddr2_ca_pkg::MR_W-1:0] o_mr_addr,
    output logic [lpddr2_ca_pkg::MR_W-1:0] o_mr_op,
    output logic o_illegal,
    output lpddr2_ca_pkg::pwr_t o_pwr,
    output logic o_autopre_valid,
    output logic [lpddr2_ca_pkg::BANK_W-1:0] o_autopre_bank
);
    localparam logic [2:0] AP_LOAD = 3'(lpddr2_ca_pkg::BURST_CYC);
    localparam logic [2:0] AP_ONE = 3'h1;
    localparam logic [2:0] AP_ZERO = 3'h0;

    logic cs_q;
    logic cke_q;
    logic cke_prev;
    logic [lpddr2_ca_pkg::CA_W-1:0] rise_q;
    logic [lpddr2_ca_pkg::CA_W-1:0] fall_q;
    logic wake_raw;
    logic wake_s1;
    logic wake_s2;
    logic wake_arm;
    logic [2:0] ap_cnt;
    logic [lpddr2_ca_pkg::BANK_W-1:0] ap_bank;

    wire [lpddr2_ca_pkg::ROW_W-1:0] f_row;
    wire [lpddr2_ca_pkg::BANK_W-1:0] f_bank;
    wire [lpddr2_ca_pkg::COL_W-1:0] f_col;
    wire f_ap;
    wire f_ab;
    wire [lpddr2_ca_pkg::MR_W-1:0] f_ma;
    wire [lpddr2_ca_pkg::MR_W-1:0] f_op;

    // capture: cs, cke and first half on rising edge
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cs_q <= 1'b1;
            cke_q <= 1'b1;
            cke_prev <= 1'b1;
            rise_q <= '0;
        end else begin
            cs_q <= link.cs_n;
            cke_q <= link.cke;
            cke_prev <= cke_q;
            rise_q <= link.ca;
        end
    end

    // second half on the falling edge of the same cycle
    always_ff @(negedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fall_q <= '0;
        end else begin
            fall_q <= link.ca;
        end
    end

    lpddr2_ca_unpack unpack (
        .i_rise(rise_q),
        .i_fall(fall_q),
        .o_row(f_row),
        .o_bank(f_bank),
        .o_col(f_col),
        .o_ap(f_ap),
        .o_all_bank(f_ab),
        .o_mr_addr(f_ma),
        .o_mr_op(f_op)
    );

    // opcode decode; only cs, ca0-3 and cke take part
    wire [3:0] op4 = rise_q[lpddr2_ca_pkg::OP4_HI:0];
    wire [2:0] op3 = rise_q[lpddr2_ca_pkg::OP3_HI:0];
    wire [1:0] op2 = rise_q[lpddr2_ca_pkg::OP2_HI:0];
    wire both_hi = cke_prev & cke_q;
    wire sel = both_hi & ~cs_q;
    wire is_nop = both_hi & (cs_q | (op3 == lpddr2_ca_pkg::OPC_NOP));
    wire is_mrw = sel & (op4 == lpddr2_ca_pkg::OPC_MRW);
    wire is_mrr = sel & (op4 == lpddr2_ca_pkg::OPC_MRR);
    wire is_ref = sel & (op3 == lpddr2_ca_pkg::OPC_REF);
    wire ref_all = rise_q[lpddr2_ca_pkg::REF_AB_BIT];
    wire pb_ok = (lpddr2_ca_pkg::NUM_BANKS == lpddr2_ca_pkg::EIGHT_BANKS);
    wire is_act = sel & (op2 == lpddr2_ca_pkg::OPC_ACT);
    wire is_wr = sel & (op3 == lpddr2_ca_pkg::OPC_WR);
    wire is_rd = sel & (op3 == lpddr2_ca_pkg::OPC_RD);
    wire is_pre = sel & (op4 == lpddr2_ca_pkg::OPC_PRE);
    wire is_bst = sel & (op4 == lpddr2_ca_pkg::OPC_BST);

    // clock-enable transitions
    wire pwr_act = (o_pwr == lpddr2_ca_pkg::PWR_ACTIVE);
    wire low_deep = (o_pwr == lpddr2_ca_pkg::PWR_SELF_REFRESH_STATE) | (o_pwr == lpddr2_ca_pkg::PWR_DPD);
    wire enter = cke_prev & ~cke_q & pwr_act;
    wire enter_pd = enter & cs_q;
    wire enter_self_refresh_state = enter & ~cs_q & (op3 == lpddr2_ca_pkg::OPC_SELF_REFRESH_STATE);
    wire enter_dpd = enter & ~cs_q & (op3 == lpddr2_ca_pkg::OPC_DPD);
    wire enter_bad = enter & ~cs_q & ~enter_self_refresh_state & ~enter_dpd;
    wire exit_edge = ~cke_prev & cke_q & cs_q & ~pwr_act;
    wire exit_bad = ~cke_prev & cke_q & ~cs_q;
    wire exit_now = exit_edge | (wake_s2 & low_deep);

    wire known = is_nop | is_mrw | is_mrr | (is_ref & (ref_all | pb_ok)) | is_act
                 | is_wr | is_rd | is_pre | is_bst;
    wire dec_illegal = (sel & ~known) | enter_bad | exit_bad;

    lpddr2_ca_pkg::cmd_t dec_cmd;
    assign dec_cmd = exit_now ? lpddr2_ca_pkg::CMD_EXIT :
                     enter_pd ? lpddr2_ca_pkg::CMD_PD_ENTER :
                     enter_self_refresh_state ? lpddr2_ca_pkg::CMD_SELF_REFRESH_STATE_ENTER :
                     enter_dpd ? lpddr2_ca_pkg::CMD_DPD_ENTER :
                     is_nop ? lpddr2_ca_pkg::CMD_NOP :
                     is_mrw ? lpddr2_ca_pkg::CMD_MRW :
                     is_mrr ? lpddr2_ca_pkg::CMD_MRR :
                     (is_ref & ref_all) ? lpddr2_ca_pkg::CMD_REF_AB :
                     is_ref ? lpddr2_ca_pkg::CMD_REF_PB :
                     is_act ? lpddr2_ca_pkg::CMD_ACT :
                     is_wr ? lpddr2_ca_pkg::CMD_WR :
                     is_rd ? lpddr2_ca_pkg::CMD_RD :
                     is_pre ? lpddr2_ca_pkg::CMD_PRE :
                     is_bst ? lpddr2_ca_pkg::CMD_BST :
                     lpddr2_ca_pkg::CMD_NOP;
    // held low cke and nop give no event
    wire dec_valid = (dec_cmd != lpddr2_ca_pkg::CMD_NOP) & ~dec_illegal;

    lpddr2_ca_pkg::pwr_t next_pwr;
    assign next_pwr = exit_now ? lpddr2_ca_pkg::PWR_ACTIVE :
                      enter_pd ? lpddr2_ca_pkg::PWR_PD :
                      enter_self_refresh_state ? lpddr2_ca_pkg::PWR_SELF_REFRESH_STATE :
                      enter_dpd ? lpddr2_ca_pkg::PWR_DPD :
                      o_pwr;

    // asynchronous wake from self refresh or deep power down
    wire wake_clr_n = i_resetn & wake_arm;
    always_ff @(posedge link.cke or negedge wake_clr_n) begin
        if (!wake_clr_n) begin
            wake_raw <= 1'b0;
        end else begin
            wake_raw <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_arm <= 1'b0;
        end else begin
            wake_s1 <= wake_raw;
            wake_s2 <= wake_s1;
            wake_arm <= low_deep & ~exit_now;
        end
    end

    // auto precharge after the burst of an access
    wire ap_start = dec_valid & (is_wr | is_rd) & f_ap;
    wire [2:0] next_ap_cnt = ap_start ? AP_LOAD :
                             (ap_cnt != AP_ZERO) ? ap_cnt - AP_ONE : AP_ZERO;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ap_cnt <= AP_ZERO;
            ap_bank <= '0;
            o_autopre_valid <= 1'b0;
            o_autopre_bank <= '0;
        end else begin
            ap_cnt <= next_ap_cnt;
            if (ap_start) begin
                ap_bank <= f_bank;
            end
            o_autopre_valid <= (ap_cnt == AP_ONE) & ~ap_start;
            o_autopre_bank <= ap_bank;
        end
    end

    // decoded command outputs
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cmd_valid <= 1'b0;
            o_cmd <= lpddr2_ca_pkg::CMD_NOP;
            o_illegal <= 1'b0;
            o_pwr <= lpddr2_ca_pkg::PWR_ACTIVE;
            o_row <= '0;
            o_bank <= '0;
            o_col <= '0;
            o_ap <= 1'b0;
            o_all_bank <= 1'b0;
            o_mr_addr <= '0;
            o_mr_op <= '0;
        end else begin
            o_cmd_valid <= dec_valid;
            o_cmd <= dec_cmd;
            o_illegal <= dec_illegal;
            o_pwr <= next_pwr;
            if (dec_valid) begin
                o_row <= f_row;
                o_bank <= f_bank;
                o_col <= f_col;
                o_ap <= f_ap;
                o_all_bank <= f_ab;
                o_mr_addr <= f_ma;
                o_mr_op <= f_op;
            end
        end
    end
endmodule

// ===== verilog/lpddr2_ca_link_if.sv
// command/address link between controller and memory device
// assumes both ends run on the same core clock; ca is double data rate
`timescale 1ns/1ps
interface lpddr2_ca_link_if;
    logic cs_n;
    logic cke;
    logic [lpddr2_ca_pkg::CA_W-1:0] ca;
    modport ctrl (output cs_n, output cke, output ca);
    modport dev (input cs_n, input cke, input ca);
endinterface

// ===== verilog/lpddr2_ca_pkg.sv
// constants shared by both ends of the command/address link
// assumes a single 100 MHz core clock on both ends
package lpddr2_ca_pkg;
    localparam int CA_W = 10;
    localparam int ROW_W = 15;
    localparam int COL_W = 12;
    localparam int BANK_W = 3;
    localparam int MR_W = 8;
    localparam int NUM_BANKS = 8;
    localparam int EIGHT_BANKS = 8;

    // opcode slices of the rising half
    localparam int OP4_HI = 3;
    localparam int OP3_HI = 2;
    localparam int OP2_HI = 1;
    localparam logic [3:0] OPC_MRW = 4'h0;
    localparam logic [3:0] OPC_MRR = 4'h8;
    localparam logic [3:0] OPC_PRE = 4'hb;
    localparam logic [3:0] OPC_BST = 4'h3;
    localparam logic [2:0] OPC_REF = 3'h4;
    localparam logic [2:0] OPC_WR = 3'h1;
    localparam logic [2:0] OPC_RD = 3'h5;
    localparam logic [2:0] OPC_NOP = 3'h7;
    localparam logic [2:0] OPC_SELF_REFRESH_STATE = 3'h4;
    localparam logic [2:0] OPC_DPD = 3'h3;
    localparam logic [1:0] OPC_ACT = 2'h2;
    localparam int REF_AB_BIT = 3;

    // field positions, r = rising half, f = falling half
    localparam int R_BANK_HI = 9;
    localparam int R_BANK_LO = 7;
    localparam int R_ROW_HI = 6;
    localparam int R_ROW_LO = 2;
    localparam int R_COL_HI = 6;
    localparam int R_COL_LO = 5;
    localparam int R_AB_BIT = 4;
    localparam int R_MA_HI = 9;
    localparam int R_MA_LO = 4;
    localparam int F_ROWH_HI = 9;
    localparam int F_ROWH_LO = 8;
    localparam int F_ROWL_HI = 7;
    localparam int F_COL_HI = 9;
    localparam int F_COL_LO = 1;
    localparam int F_AP_BIT = 0;
    localparam int F_MA_HI = 1;
    localparam int F_OP_HI = 9;
    localparam int F_OP_LO = 2;
    localparam int MA_RISE_W = 6;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0, CMD_MRW = 4'h1, CMD_MRR = 4'h2, CMD_REF_PB = 4'h3,
        CMD_REF_AB = 4'h4, CMD_ACT = 4'h5, CMD_WR = 4'h6, CMD_RD = 4'h7,
        CMD_PRE = 4'h8, CMD_BST = 4'h9, CMD_PD_ENTER = 4'ha,
        CMD_SELF_REFRESH_STATE_ENTER = 4'hb, CMD_DPD_ENTER = 4'hc, CMD_EXIT = 4'hd
    } cmd_t;

    typedef enum logic [3:0] {
        PWR_ACTIVE = 4'h1, PWR_PD = 4'h2, PWR_SELF_REFRESH_STATE = 4'h4, PWR_DPD = 4'h8
    } pwr_t;

    localparam int CLK_PERIOD_NS = 10;
    localparam int PD_EXIT_TIME_NS = 15;
    localparam int PD_EXIT_CYC = (PD_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XP_W = 4;
    localparam int BURST_CYC = 4;

    // controller register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ARG0 = 4'h4;
    localparam logic [3:0] REG_ARG1 = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int A1_AP_BIT = 3;
    localparam int A1_AB_BIT = 4;
    localparam int A1_OP_HI = 15;
    localparam int A1_OP_LO = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_PWR_LO = 4;
endpackage

// ===== verilog/lpddr2_ca_unpack.sv
// splits the two captured halves of a command into its fields
// assumes both halves belong to the same command
`timescale 1ns/1ps
module lpddr2_ca_unpack (
    input wire logic [lpddr2_ca_pkg::CA_W-1:0] i_rise,
    input wire logic [lpddr2_ca_pkg::CA_W-1:0] i_fall,
    output logic [lpddr2_ca_pkg::ROW_W-1:0] o_row,
    output logic [lpddr2_ca_pkg::BANK_W-1:0] o_bank,
    output logic [lpddr2_ca_pkg::COL_W-1:0] o_col,
    output logic o_ap,
    output logic o_all_bank,
    output logic [lpddr2_ca_pkg::MR_W-1:0] o_mr_addr,
    output logic [lpddr2_ca_pkg::MR_W-1:0] o_mr_op
);
    assign o_row = {i_fall[lpddr2_ca_pkg::F_ROWH_HI:lpddr2_ca_pkg::F_ROWH_LO],
                    i_rise[lpddr2_ca_pkg::R_ROW_HI:lpddr2_ca_pkg::R_ROW_LO],
                    i_fall[lpddr2_ca_pkg::F_ROWL_HI:0]};
    assign o_bank = i_rise[lpddr2_ca_pkg::R_BANK_HI:lpddr2_ca_pkg::R_BANK_LO];
    assign o_col = {i_fall[lpddr2_ca_pkg::F_COL_HI:lpddr2_ca_pkg::F_COL_LO],
                    i_rise[lpddr2_ca_pkg::R_COL_HI:lpddr2_ca_pkg::R_COL_LO],
                    1'b0};
    assign o_ap = i_fall[lpddr2_ca_pkg::F_AP_BIT];
    assign o_all_bank = i_rise[lpddr2_ca_pkg::R_AB_BIT];
    assign o_mr_addr = {i_fall[lpddr2_ca_pkg::F_MA_HI:0],
                        i_rise[lpddr2_ca_pkg::R_MA_HI:lpddr2_ca_pkg::R_MA_LO]};
    assign o_mr_op = i_fall[lpddr2_ca_pkg::F_OP_HI:lpddr2_ca_pkg::F_OP_LO];
endmodule
